// ===== src/brs_consts.svh
// Constants for the breaker reclose sequencer: offsets, reset values, timing
`ifndef BRS_CONSTS_SVH
`define BRS_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BRS_ADDR_CTRL     8'h00
`define BRS_ADDR_T_DEAD   8'h04
`define BRS_ADDR_T_RESET  8'h08
`define BRS_ADDR_T_INC    8'h0C
`define BRS_ADDR_T_MCH    8'h10
`define BRS_ADDR_STATUS   8'h14
`define BRS_ADDR_INT_ST   8'h18
`define BRS_ADDR_INT_MASK 8'h1C
`define BRS_ADDR_EVLOG    8'h20
`define BRS_ADDR_SUPV     8'h24

// ----------------------------------------------------------------
// Reset values (timer values are in time-base ticks)
// ----------------------------------------------------------------
`define BRS_SHOTS_RST     3'h4
`define BRS_T_DEAD_RST    16'h03E8
`define BRS_T_RESET_RST   16'h7530
`define BRS_T_INC_RST     16'h1388
`define BRS_T_MCH_RST     16'h1388
`define BRS_MASK_RST      6'h00

// ----------------------------------------------------------------
// Event bits in the interrupt status register
// ----------------------------------------------------------------
`define BRS_EV_W          6
`define BRS_EV_REQ        0
`define BRS_EV_ROPEN      1
`define BRS_EV_RECLOSE    2
`define BRS_EV_AUTORST    3
`define BRS_EV_LOCK       4
`define BRS_EV_KEYRST     5

// ----------------------------------------------------------------
// Shot counts that expose the supervision limits
// ----------------------------------------------------------------
`define BRS_SHOTS_LIM2    3'h3
`define BRS_SHOTS_LIM3    3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BRS_TICK_NS       1000000
`define BRS_CLK_NS        25

`endif

// ===== src/brs_pkg.sv
// Types shared by the breaker reclose sequencer files
package brs_pkg;

	typedef enum logic [1:0] {
		BRS_ST_ENABLED  = 2'b00,
		BRS_ST_DISABLED = 2'b01,
		BRS_ST_IN_PROG  = 2'b10,
		BRS_ST_LOCKOUT  = 2'b11
	} brs_state_t;

	typedef enum logic [1:0] {
		BRS_PH_IDLE       = 2'b00,
		BRS_PH_WAIT_TRIP  = 2'b01,
		BRS_PH_DEAD       = 2'b10,
		BRS_PH_RESET_WAIT = 2'b11
	} brs_phase_t;

	typedef struct packed {
		logic inhibit;
		logic abort;
		logic request;
		logic remote_open;
		logic manual_close;
		logic reset_key;
		logic toc_pickup;
		logic oc_trip;
		logic bkr_fail;
		logic bkr_closed;
	} brs_pins_t;

	typedef struct packed {
		logic enabled;
		logic disabled;
		logic in_progress;
		logic lockout;
	} brs_ind_t;

endpackage

// ===== src/brs_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels
`timescale 1ns/10ps
module brs_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule // brs_sync

// ===== src/brs_timer.sv
// Tick-driven countdown timer with a one-cycle expiry pulse
`timescale 1ns/10ps
module brs_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	output logic             run,
	output logic             expired
);
	logic [15:0] cnt_ff;
	logic        run_ff;
	logic        exp_ff;
	logic [15:0] nxt_cnt;
	logic        nxt_run;
	logic        nxt_exp;
	logic        done;

	// A zero value expires on the first tick, as a value of one does
	assign done    = run_ff & tick & (cnt_ff <= 16'h0001);
	assign nxt_exp = done & ~load;
	assign nxt_run = load | (run_ff & ~done);
	assign nxt_cnt = load ? load_val : ((run_ff & tick) ? cnt_ff - 16'h0001 : cnt_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 16'h0000;
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			exp_ff <= nxt_exp;
		end
	end

	assign run     = run_ff;
	assign expired = exp_ff;
endmodule // brs_timer

// ===== src/brs_reclose_seq.sv
// Automatic reclose sequencer with APB registers, timers and event log
//
// Notes on behaviour
// - Manual close holds scheme disabled for the manual-close hold time.
// - When the hold ends, scheme returns to enabled; in-progress and disabled off.
// - Inhibit input shows disabled; release returns to enabled.
// - Abort input shows disabled; release restores enabled.
// - Request pulse puts enabled scheme into in-progress at once.
// - No breaker trip before unfinished-sequence timer expiry cancels in-progress.
// - Inhibit cancels in-progress; request while inhibited starts on release.
// - Abort during in-progress disables and cancels; release re-enables.
// - Manual close ignored in dead time; dead end recloses, attempt count rises.
// - Attempts left is shots less used; reset timer expiry restores full count.
// - Log request, remote open, reclose, automatic reset and lockout events.
// - Initiation with no attempts left drives lockout with its indications.
// - Reset key clears lockout, restores count, logs reset, indicates enabled.
// - Close from lockout without fault clears lockout at hold end.
// - Overcurrent pickup during hold after close from lockout keeps lockout, trips.
// - Trip-and-reclose element starts reclosing; breaker failure forces lockout.
// - Supervision limits available follow the programmed shot count.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "brs_consts.svh"
module brs_reclose_seq
	import brs_pkg::*;
#(
	parameter int TICK_CYCLES = `BRS_TICK_NS / `BRS_CLK_NS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire brs_pins_t   pins_in,
	output brs_ind_t         ind_out,
	output logic             close_cmd,
	output logic             trip_cmd,
	output logic             irq
);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// ----------------------------------------------------------------
	// Pin synchronisation and edges
	// ----------------------------------------------------------------
	brs_pins_t pin_s;
	brs_pins_t pin_d_ff;
	brs_pins_t rise;
	logic      bkr_trip;

	brs_sync #(.W($bits(brs_pins_t))) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pins_in),
		.q       (pin_s)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_d_ff <= '0;
		end else begin
			pin_d_ff <= pin_s;
		end
	end

	assign rise     = pin_s & ~pin_d_ff;
	assign bkr_trip = pin_d_ff.bkr_closed & ~pin_s.bkr_closed;

	// ----------------------------------------------------------------
	// Common time base
	// ----------------------------------------------------------------
	logic [15:0] tick_cnt_ff;
	logic        tick_ff;
	logic [15:0] ts_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= 16'h0000;
			tick_ff     <= 1'b0;
			ts_ff       <= 16'h0000;
		end else begin
			tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? 16'h0000 : tick_cnt_ff + 16'h0001;
			tick_ff     <= (tick_cnt_ff == TICK_LAST);
			ts_ff       <= ts_ff + {15'h0000, tick_ff};
		end
	end

	// ----------------------------------------------------------------
	// APB slave and registers
	// ----------------------------------------------------------------
	logic [2:0]           shots_ff;
	logic [15:0]          t_dead_ff;
	logic [15:0]          t_reset_ff;
	logic [15:0]          t_inc_ff;
	logic [15:0]          t_mch_ff;
	logic [`BRS_EV_W-1:0] int_st_ff;
	logic [`BRS_EV_W-1:0] int_mask_ff;
	logic [`BRS_EV_W-1:0] last_ev_ff;
	logic [15:0]          ev_ts_ff;
	logic [31:0]          prdata_ff;
	logic                 pready_ff;
	logic                 pslverr_ff;
	logic                 irq_ff;

	logic                 acc;
	logic                 wr_en;
	logic                 hit_ctrl;
	logic                 hit_dead;
	logic                 hit_reset;
	logic                 hit_inc;
	logic                 hit_mch;
	logic                 hit_status;
	logic                 hit_int_st;
	logic                 hit_mask;
	logic                 hit_evlog;
	logic                 hit_supv;
	logic                 mapped;
	logic [31:0]          rd_mux;
	logic [31:0]          status_word;
	logic [2:0]           supv_avail;
	logic [`BRS_EV_W-1:0] ev_vec;
	logic [`BRS_EV_W-1:0] nxt_int_st;

	// One wait state: pready rises in the cycle after the access phase starts
	assign acc        = psel & penable & ~pready_ff;
	assign wr_en      = psel & penable & pready_ff & pwrite;
	assign hit_ctrl   = (paddr == `BRS_ADDR_CTRL);
	assign hit_dead   = (paddr == `BRS_ADDR_T_DEAD);
	assign hit_reset  = (paddr == `BRS_ADDR_T_RESET);
	assign hit_inc    = (paddr == `BRS_ADDR_T_INC);
	assign hit_mch    = (paddr == `BRS_ADDR_T_MCH);
	assign hit_status = (paddr == `BRS_ADDR_STATUS);
	assign hit_int_st = (paddr == `BRS_ADDR_INT_ST);
	assign hit_mask   = (paddr == `BRS_ADDR_INT_MASK);
	assign hit_evlog  = (paddr == `BRS_ADDR_EVLOG);
	assign hit_supv   = (paddr == `BRS_ADDR_SUPV);
	assign mapped     = hit_ctrl | hit_dead | hit_reset | hit_inc | hit_mch | hit_status
	                  | hit_int_st | hit_mask | hit_evlog | hit_supv;

	// Limits hidden as the shot count drops
	assign supv_avail = {shots_ff >= `BRS_SHOTS_LIM3, shots_ff >= `BRS_SHOTS_LIM2, 1'b1};

	assign rd_mux = hit_ctrl   ? {29'h00000000, shots_ff} :
	                hit_dead   ? {16'h0000, t_dead_ff} :
	                hit_reset  ? {16'h0000, t_reset_ff} :
	                hit_inc    ? {16'h0000, t_inc_ff} :
	                hit_mch    ? {16'h0000, t_mch_ff} :
	                hit_status ? status_word :
	                hit_int_st ? {26'h0000000, int_st_ff} :
	                hit_mask   ? {26'h0000000, int_mask_ff} :
	                hit_evlog  ? {ev_ts_ff, 10'h000, last_ev_ff} :
	                hit_supv   ? {29'h00000000, supv_avail} : 32'h00000000;

	// Hardware set wins over a write-one-to-clear in the same cycle
	assign nxt_int_st = (int_st_ff & ~((wr_en & hit_int_st) ? pwdata[`BRS_EV_W-1:0] : '0))
	                  | ev_vec;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= acc;
			pslverr_ff <= acc & ~mapped;
			prdata_ff  <= acc ? rd_mux : prdata_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shots_ff    <= `BRS_SHOTS_RST;
			t_dead_ff   <= `BRS_T_DEAD_RST;
			t_reset_ff  <= `BRS_T_RESET_RST;
			t_inc_ff    <= `BRS_T_INC_RST;
			t_mch_ff    <= `BRS_T_MCH_RST;
			int_mask_ff <= `BRS_MASK_RST;
		end else if (wr_en) begin
			if (hit_ctrl) shots_ff <= pwdata[2:0];
			if (hit_dead) t_dead_ff <= pwdata[15:0];
			if (hit_reset) t_reset_ff <= pwdata[15:0];
			if (hit_inc) t_inc_ff <= pwdata[15:0];
			if (hit_mch) t_mch_ff <= pwdata[15:0];
			if (hit_mask) int_mask_ff <= pwdata[`BRS_EV_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_st_ff  <= '0;
			last_ev_ff <= '0;
			ev_ts_ff   <= 16'h0000;
			irq_ff     <= 1'b0;
		end else begin
			int_st_ff  <= nxt_int_st;
			last_ev_ff <= (|ev_vec) ? ev_vec : last_ev_ff;
			ev_ts_ff   <= (|ev_vec) ? ts_ff : ev_ts_ff;
			irq_ff     <= |(nxt_int_st & int_mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// Scheme timers
	// ----------------------------------------------------------------
	logic ld_inc;
	logic ld_dead;
	logic ld_reset;
	logic ld_mch;
	logic inc_exp;
	logic dead_exp;
	logic reset_exp;
	logic mch_exp;
	logic mch_run;

	brs_timer u_t_inc (
		.pclk (pclk), .presetn (presetn), .tick (tick_ff), .load (ld_inc),
		.load_val (t_inc_ff), .run (), .expired (inc_exp)
	);
	brs_timer u_t_dead (
		.pclk (pclk), .presetn (presetn), .tick (tick_ff), .load (ld_dead),
		.load_val (t_dead_ff), .run (), .expired (dead_exp)
	);
	brs_timer u_t_reset (
		.pclk (pclk), .presetn (presetn), .tick (tick_ff), .load (ld_reset),
		.load_val (t_reset_ff), .run (), .expired (reset_exp)
	);
	brs_timer u_t_mch (
		.pclk (pclk), .presetn (presetn), .tick (tick_ff), .load (ld_mch),
		.load_val (t_mch_ff), .run (mch_run), .expired (mch_exp)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	brs_state_t state_ff;
	brs_state_t nxt_state;
	brs_phase_t phase_ff;
	brs_phase_t nxt_phase;
	logic [2:0] attempt_ff;
	logic [2:0] nxt_attempt;
	logic [2:0] left_ff;
	logic [2:0] nxt_left;
	logic       pend_ff;
	logic       nxt_pend;
	logic       from_lock_ff;
	logic       fault_ff;
	logic       close_ff;
	logic       trip_ff;
	brs_ind_t   ind_ff;
	logic       initiate;
	logic       goto_lock;
	logic       manual_ok;
	logic       ev_reclose;
	logic       ev_auto;
	logic       ev_lock;
	logic       ev_keyrst;

	assign initiate  = rise.request | rise.oc_trip;
	assign goto_lock = rise.bkr_fail | (initiate & (left_ff == 3'h0));
	// Manual close is blocked while a sequence owns the breaker
	assign manual_ok = rise.manual_close & (state_ff != BRS_ST_IN_PROG);
	assign ld_mch    = manual_ok;

	assign ev_vec = {ev_keyrst, ev_lock, ev_auto, ev_reclose, rise.remote_open, rise.request};
	assign status_word = {21'h000000, pend_ff, phase_ff, state_ff, left_ff, attempt_ff};

	always_comb begin
		nxt_state   = state_ff;
		nxt_phase   = phase_ff;
		nxt_attempt = attempt_ff;
		nxt_left    = left_ff;
		nxt_pend    = pend_ff;
		ld_inc      = 1'b0;
		ld_dead     = 1'b0;
		ld_reset    = 1'b0;
		ev_reclose  = 1'b0;
		ev_auto     = 1'b0;
		ev_lock     = 1'b0;
		ev_keyrst   = 1'b0;
		case (state_ff)
			BRS_ST_LOCKOUT: begin
				// Close from lockout clears only if no pickup seen during hold
				if (rise.reset_key || (mch_exp && from_lock_ff && !fault_ff)) begin
					nxt_state   = BRS_ST_ENABLED;
					nxt_phase   = BRS_PH_IDLE;
					nxt_attempt = 3'h0;
					nxt_left    = shots_ff;
					ev_keyrst   = 1'b1;
				end
			end
			BRS_ST_ENABLED, BRS_ST_DISABLED, BRS_ST_IN_PROG: begin
				if (goto_lock) begin
					nxt_state = BRS_ST_LOCKOUT;
					nxt_phase = BRS_PH_IDLE;
					nxt_pend  = 1'b0;
					ev_lock   = 1'b1;
				end else if (pin_s.inhibit || pin_s.abort || mch_run) begin
					nxt_state = BRS_ST_DISABLED;
					nxt_phase = BRS_PH_IDLE;
					nxt_pend  = (pend_ff | (initiate & pin_s.inhibit)) & ~pin_s.abort;
				end else if (state_ff == BRS_ST_IN_PROG) begin
					if (phase_ff == BRS_PH_WAIT_TRIP) begin
						if (bkr_trip) begin
							nxt_phase = BRS_PH_DEAD;
							ld_dead   = 1'b1;
						end else if (inc_exp) begin
							nxt_state = BRS_ST_ENABLED;
							nxt_phase = BRS_PH_IDLE;
						end
					end else if (phase_ff == BRS_PH_DEAD) begin
						if (dead_exp) begin
							nxt_state   = BRS_ST_ENABLED;
							nxt_phase   = BRS_PH_RESET_WAIT;
							nxt_attempt = attempt_ff + 3'h1;
							nxt_left    = left_ff - 3'h1;
							ld_reset    = 1'b1;
							ev_reclose  = 1'b1;
						end
					end else begin
						nxt_state = BRS_ST_ENABLED;
						nxt_phase = BRS_PH_IDLE;
					end
				end else if (initiate || pend_ff) begin
					nxt_state = BRS_ST_IN_PROG;
					nxt_phase = BRS_PH_WAIT_TRIP;
					nxt_pend  = 1'b0;
					ld_inc    = 1'b1;
				end else begin
					nxt_state = BRS_ST_ENABLED;
					if (phase_ff == BRS_PH_RESET_WAIT && reset_exp) begin
						nxt_phase   = BRS_PH_IDLE;
						nxt_attempt = 3'h0;
						nxt_left    = shots_ff;
						ev_auto     = 1'b1;
					end
				end
			end
			default: begin
				nxt_state = BRS_ST_ENABLED;
				nxt_phase = BRS_PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= BRS_ST_ENABLED;
			phase_ff   <= BRS_PH_IDLE;
			attempt_ff <= 3'h0;
			left_ff    <= `BRS_SHOTS_RST;
			pend_ff    <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			phase_ff   <= nxt_phase;
			attempt_ff <= nxt_attempt;
			left_ff    <= nxt_left;
			pend_ff    <= nxt_pend;
		end
	end

	// Fault watch over the hold after a close from lockout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			from_lock_ff <= 1'b0;
			fault_ff     <= 1'b0;
		end else begin
			from_lock_ff <= ld_mch ? (state_ff == BRS_ST_LOCKOUT) : from_lock_ff;
			fault_ff     <= ld_mch ? 1'b0 : (fault_ff | (mch_run & pin_s.toc_pickup));
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			close_ff <= 1'b0;
			trip_ff  <= 1'b0;
			ind_ff   <= '0;
		end else begin
			close_ff <= ev_reclose | manual_ok;
			// Time-overcurrent trip timing is the element's own; it is passed on here
			trip_ff  <= pin_s.remote_open | pin_s.oc_trip | (fault_ff & pin_s.toc_pickup);
			ind_ff.enabled     <= (nxt_state == BRS_ST_ENABLED);
			ind_ff.disabled    <= (nxt_state == BRS_ST_DISABLED) | (nxt_state == BRS_ST_LOCKOUT);
			ind_ff.in_progress <= (nxt_state == BRS_ST_IN_PROG);
			ind_ff.lockout     <= (nxt_state == BRS_ST_LOCKOUT);
		end
	end

	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;
	assign irq       = irq_ff;
	assign close_cmd = close_ff;
	assign trip_cmd  = trip_ff;
	assign ind_out   = ind_ff;
endmodule // brs_reclose_seq

// ===== sim/brs_reclose_seq_sva.sv
// Assertion checker for the reclose sequencer indications and close command
`timescale 1ns/10ps
module brs_reclose_seq_sva
	import brs_pkg::*;
#(
	parameter int TICK_CYCLES = 4
) (
	input wire logic      pclk,
	input wire logic      presetn,
	input wire brs_pins_t pins_in,
	input wire brs_ind_t  ind_out,
	input wire logic      close_cmd
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	// Six cycles covers two sync flops, edge register and indication
	sequence s_inh_held;
		pins_in.inhibit [*6];
	endsequence
	sequence s_abt_held;
		pins_in.abort [*6];
	endsequence
	sequence s_req_taken;
		$rose(pins_in.request) && ind_out.enabled && !pins_in.inhibit && !pins_in.abort;
	endsequence
	AST_ONE_STATE: assert property ($onehot0({ind_out.enabled, ind_out.disabled, ind_out.in_progress}))
		else $error("several scheme states shown");
	AST_LOCK_IND: assert property (ind_out.lockout |-> ind_out.disabled && !ind_out.enabled)
		else $error("lockout indications wrong");
	AST_INHIBIT: assert property (s_inh_held |-> ind_out.disabled && !ind_out.enabled)
		else $error("inhibit not shown as disabled");
	AST_ABORT: assert property (s_abt_held |-> ind_out.disabled && !ind_out.enabled)
		else $error("abort not shown as disabled");
	AST_INH_CANCEL: assert property (s_inh_held |-> !ind_out.in_progress)
		else $error("in progress under inhibit");
	AST_ABT_CANCEL: assert property (s_abt_held |-> !ind_out.in_progress)
		else $error("in progress under abort");
	AST_REQ_START: assert property (s_req_taken |-> ##[2:6] (ind_out.in_progress || ind_out.lockout))
		else $error("request did not start a sequence");
	AST_CLOSE_PULSE: assert property (close_cmd |=> !close_cmd)
		else $error("close command longer than one cycle");
	AST_BKR_FAIL: assert property ($rose(pins_in.bkr_fail) |-> ##[2:6] ind_out.lockout)
		else $error("breaker failure did not lock out");
endmodule // brs_reclose_seq_sva

bind brs_reclose_seq brs_reclose_seq_sva #(
	.TICK_CYCLES(TICK_CYCLES)
) u_brs_reclose_seq_sva (
	.pclk     (pclk),
	.presetn  (presetn),
	.pins_in  (pins_in),
	.ind_out  (ind_out),
	.close_cmd(close_cmd)
);

// ===== sim/brs_breaker.sv
// Behavioural circuit breaker driven by the trip and close commands
`timescale 1ns/10ps
module brs_breaker (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic trip_cmd,
	input  wire logic close_cmd,
	input  wire logic trip_cut,
	output logic      bkr_closed
);
	logic [1:0] trip_dly_ff;
	// Open test switch keeps the breaker closed so failure can be seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_dly_ff <= 2'h0;
			bkr_closed  <= 1'b0;
		end else begin
			trip_dly_ff <= {trip_dly_ff[0], trip_cmd & ~trip_cut};
			if (close_cmd)
				bkr_closed <= 1'b1;
			else if (trip_dly_ff[1])
				bkr_closed <= 1'b0;
		end
	end
endmodule // brs_breaker

// ===== sim/tb_top.sv
// Self-checking bench for the breaker reclose sequencer
`timescale 1ns/10ps
`include "brs_consts.svh"
module tb_top
	import brs_pkg::*;
;
	localparam int TK = 4;
	localparam logic [3:0] EN = 4'h8;
	localparam logic [3:0] DIS = 4'h4;
	localparam logic [3:0] PRG = 4'h2;
	localparam logic [3:0] LCK = 4'h5;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        close_cmd;
	logic        trip_cmd;
	logic        irq;
	logic        bkr_closed;
	logic        trip_cut = 1'b0;
	brs_pins_t   drv = '0;
	brs_pins_t   pins_in;
	brs_ind_t    ind_out;
	logic [31:0] rd;
	logic        err;
	logic [31:0] lfsr = 32'hB92F9797;
	int          errors = 0;
	int          n_compared = 0;
	int          m_left = 4;
	int          m_cnt = 0;
	int          dead;
	int          n;

	assign pins_in = {drv[9:1], bkr_closed};
	always #12.5 pclk = ~pclk;

	brs_reclose_seq #(.TICK_CYCLES(TK)) u_brs_reclose_seq (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins_in(pins_in), .ind_out(ind_out), .close_cmd(close_cmd), .trip_cmd(trip_cmd),
		.irq(irq));
	brs_breaker u_brs_breaker (.pclk(pclk), .presetn(presetn), .trip_cmd(trip_cmd),
		.close_cmd(close_cmd), .trip_cut(trip_cut), .bkr_closed(bkr_closed));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask

	function automatic logic [31:0] nxt_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic logic [31:0] st(input logic [1:0] s);
		return {24'h0, s, m_left[2:0], m_cnt[2:0]};
	endfunction

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask

	task automatic pulse(input int i);
		@(posedge pclk);
		drv[i] <= 1'b1;
		wt(2);
		drv[i] <= 1'b0;
	endtask

	task automatic ind(input logic [3:0] e);
		check({28'h0, ind_out}, {28'h0, e});
	endtask

	// Request, remote open, then a manual close that must be ignored
	task automatic shot;
		lfsr = nxt_rand(lfsr);
		dead = 3 + int'(lfsr[1:0]);
		apb(1'b1, `BRS_ADDR_T_DEAD, 32'(dead));
		pulse(7);
		pulse(6);
		wt(4);
		pulse(5);
		n = 13;
		while (close_cmd !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		check(32'(n >= (dead - 1) * TK + 10 && n <= dead * TK + 24), 32'h1);
		m_left--;
		m_cnt++;
		wt(3);
		ind(EN);
		rdchk(`BRS_ADDR_STATUS, 32'hFF, st(2'h0));
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		wt(10);
		presetn <= 1'b1;
		wt(3);
		rdchk(`BRS_ADDR_STATUS, 32'hFFFFFFFF, 32'h20);
		rdchk(`BRS_ADDR_CTRL, 32'h7, 32'h4);
		ind(EN);
		apb(1'b0, 8'h40, 32'h0);
		check({rd[31:1], err}, 32'h1);
		for (int s = 2; s <= 4; s++) begin
			apb(1'b1, `BRS_ADDR_CTRL, 32'(s));
			rdchk(`BRS_ADDR_SUPV, 32'h7, (s == 4) ? 32'h7 : (s == 3) ? 32'h3 : 32'h1);
		end
		apb(1'b1, `BRS_ADDR_T_INC, 32'h5);
		apb(1'b1, `BRS_ADDR_T_MCH, 32'h3);
		apb(1'b1, `BRS_ADDR_T_RESET, 32'hA);
		$display("test registers finished");
		pulse(5);
		wt(4);
		ind(DIS);
		check(32'(bkr_closed), 32'h1);
		wt(16);
		ind(EN);
		for (int i = 9; i >= 8; i--) begin
			@(posedge pclk);
			drv[i] <= 1'b1;
			wt(6);
			ind(DIS);
			drv[i] <= 1'b0;
			wt(6);
			ind(EN);
		end
		$display("test hold and blocking finished");
		pulse(7);
		wt(3);
		ind(PRG);
		rdchk(`BRS_ADDR_INT_ST, 32'h3F, 32'h1);
		check(32'(irq), 32'h0);
		apb(1'b1, `BRS_ADDR_INT_MASK, 32'h3F);
		wt(2);
		check(32'(irq), 32'h1);
		wt(24);
		ind(EN);
		apb(1'b1, `BRS_ADDR_INT_ST, 32'h3F);
		wt(2);
		check(32'(irq), 32'h0);
		pulse(7);
		wt(3);
		ind(PRG);
		drv.inhibit <= 1'b1;
		wt(6);
		ind(DIS);
		pulse(7);
		wt(4);
		ind(DIS);
		drv.inhibit <= 1'b0;
		wt(6);
		ind(PRG);
		drv.abort <= 1'b1;
		wt(6);
		ind(DIS);
		drv.abort <= 1'b0;
		wt(6);
		ind(EN);
		$display("test in progress finished");
		apb(1'b1, `BRS_ADDR_INT_ST, 32'h3F);
		shot;
		rdchk(`BRS_ADDR_INT_ST, 32'h3F, 32'h7);
		wt(60);
		m_left = 4;
		m_cnt = 0;
		rdchk(`BRS_ADDR_STATUS, 32'hFF, st(2'h0));
		rdchk(`BRS_ADDR_INT_ST, 32'h3F, 32'hF);
		rdchk(`BRS_ADDR_EVLOG, 32'h3F, 32'h8);
		repeat (4) shot;
		pulse(7);
		wt(3);
		ind(LCK);
		rdchk(`BRS_ADDR_STATUS, 32'hFF, st(2'h3));
		rdchk(`BRS_ADDR_INT_ST, 32'h10, 32'h10);
		pulse(4);
		wt(3);
		ind(EN);
		m_left = 4;
		m_cnt = 0;
		rdchk(`BRS_ADDR_STATUS, 32'hFF, st(2'h0));
		rdchk(`BRS_ADDR_INT_ST, 32'h20, 32'h20);
		$display("test shots and lockout finished");
		trip_cut <= 1'b1;
		drv.oc_trip <= 1'b1;
		wt(6);
		ind(PRG);
		pulse(1);
		wt(3);
		ind(LCK);
		drv.oc_trip <= 1'b0;
		pulse(4);
		wt(3);
		ind(EN);
		$display("test breaker failure finished");
		// Close from lockout with no fault: lockout kept over the hold, then cleared
		pulse(1);
		wt(3);
		ind(LCK);
		pulse(5);
		wt(4);
		ind(LCK);
		wt(16);
		ind(EN);
		check(32'(trip_cmd), 32'h0);
		// Close from lockout onto a pickup: lockout stays and the breaker trips
		pulse(1);
		wt(3);
		ind(LCK);
		trip_cut <= 1'b0;
		drv.toc_pickup <= 1'b1;
		pulse(5);
		wt(20);
		ind(LCK);
		check(32'(trip_cmd), 32'h1);
		check(32'(bkr_closed), 32'h0);
		drv.toc_pickup <= 1'b0;
		pulse(4);
		wt(3);
		ind(EN);
		check(32'(trip_cmd), 32'h0);
		$display("test close from lockout finished");
		report_and_stop;
	end

	// Whole run needs about 600 cycles; far beyond that means a hang
	initial begin
		wt(30000);
		errors++;
		report_and_stop;
	end
endmodule // tb_top
